// *** bench/llsd_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module llsd_line_model
    import llsd_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [1:0][2:0]  period,
    input  wire logic [1:0]       low,
    output var  llsd_line_t [1:0] line
);
    logic [1:0][2:0] cnt_r;
    logic [3:0]      div_r;

    // Pulse spacing counters; period 0 means a dead line of zeros.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            div_r <= '0;
        end else begin
            div_r <= div_r + 4'h1;
            for (int c = 0; c < 2; c++) begin
                cnt_r[c] <= (cnt_r[c] + 3'h1 >= period[c]) ? 3'h0
                                                           : cnt_r[c] + 3'h1;
            end
        end
    end

    // One symbol a cycle; the three clocks differ in rate so a wrong
    // selection at the receive clock output is always visible.
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            line[c].sym_valid = arst_n;
            line[c].pos       = period[c] != 3'h0 && cnt_r[c] == 3'h0
                                && div_r[0];
            line[c].neg       = period[c] != 3'h0 && cnt_r[c] == 3'h0
                                && !div_r[0];
            line[c].level_low = low[c];
            line[c].rec_clk   = div_r[0];
            line[c].ref_clk   = div_r[1];
            line[c].syn_clk   = div_r[2];
        end
    end
endmodule : llsd_line_model
`default_nettype wire

// *** bench/llsd_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module llsd_props
    import llsd_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             arst_n,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    input wire logic             control_source_select,
    input wire logic             loss_data_mute,
    input wire logic             single_frequency_operation,
    input wire llsd_line_t [1:0] line_in,
    input wire logic [1:0]       receive_clock_out,
    input wire logic [1:0]       receive_positive_rail,
    input wire logic [1:0]       receive_negative_rail,
    input wire logic [1:0]       combined_receive_loss,
    input wire logic             host_int_n
);
    // ********
    // Channel 0 views
    // ********
    // Channel 0 is watched here; the bench covers channel 1 itself.
    wire cr0  = combined_receive_loss[0];
    wire onef = single_frequency_operation;
    wire mpin = !control_source_select && loss_data_mute;
    wire rl0  = receive_positive_rail[0] | receive_negative_rail[0];

    default clocking dck @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // ********
    // Register bus
    // ********
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    answer_time_a: assert property (
        (psel && !penable) ##1 (psel && penable) |=> pready)
        else $error("pready missing two cycles after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside a completing access");
    rdata_idle_a: assert property (
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero while idle");

    // ********
    // Loss handling
    // ********
    // A three-cycle window hides which internal flop drives the mux.
    mute_rails_a: assert property (
        (cr0 && mpin) [*3] |-> !$past(rl0))
        else $error("rails not muted during loss");
    loss_clock_a: assert property (
        (cr0 && !onef) [*3] |->
        $past(receive_clock_out[0]) == $past(line_in[0].ref_clk, 2))
        else $error("reference clock missing during loss");
    loss_synclk_a: assert property (
        (cr0 && onef) [*3] |->
        $past(receive_clock_out[0]) == $past(line_in[0].syn_clk, 2))
        else $error("synthesised clock missing during loss");
    data_resume_a: assert property (
        (!cr0) [*3] |->
        $past(receive_positive_rail[0]) == $past(line_in[0].pos, 2)
        && $past(receive_clock_out[0]) == $past(line_in[0].rec_clk, 2))
        else $error("recovered data or clock not passed through");
    int_pinmode_a: assert property (
        !control_source_select |=> host_int_n)
        else $error("interrupt low in pin mode");

    cover property (cr0 ##1 !cr0);
    cover property ((cr0 && onef) [*3]);
    cover property ($fell(host_int_n));
endmodule : llsd_props
`default_nettype wire

// *** bench/llsd_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module llsd_top_test
    import llsd_pkg::*;
;
    logic             clk_sys = 1'b0;
    logic             arst_n  = 1'b0;
    logic [11:0]      paddr   = 12'h000;
    logic             psel    = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite  = 1'b0;
    logic [31:0]      pwdata  = 32'h0000_0000;
    logic             css     = 1'b0;
    logic             mute    = 1'b0;
    logic             onef    = 1'b0;
    logic [1:0]       dfa     = 2'b00;
    logic [1:0]       hwe3    = 2'b00;
    logic [1:0][2:0]  period  = {3'h1, 3'h1};
    logic [1:0]       low     = 2'b00;
    logic             pready, pslverr, host_int_n;
    logic [31:0]      prdata;
    logic [1:0]       rclk, rpos, rneg, loss;
    logic [1:0]       all_loss, any_loss, any_rail;
    llsd_line_t [1:0] line_in;
    int               failures = 0;
    int               checked  = 0;

    llsd_line_model llsd_line_model_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .period(period), .low(low),
        .line(line_in));
    llsd_top llsd_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .control_source_select(css), .hw_e3_select(hwe3),
        .loss_data_mute(mute), .single_frequency_operation(onef),
        .line_in(line_in), .driver_fault_alarm(dfa),
        .receive_clock_out(rclk), .receive_positive_rail(rpos),
        .receive_negative_rail(rneg), .combined_receive_loss(loss),
        .host_int_n(host_int_n));

    // Free-running 200 MHz system clock.
    always #2.5 clk_sys = ~clk_sys;

    // ********
    // Helpers
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // One transfer; on a read d is the expected data.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            test_done();
        end
        check({31'h0, pslverr}, {31'h0, err});
        if (!wr) check(prdata, d);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Waits for a loss pin level; the time taken must lie in [lo, hi].
    task automatic await(input int ch, input logic lvl, input int lo,
                         input int hi);
        int n;
        n = 0;
        while (loss[ch] !== lvl && n <= hi) begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h0000_0001);
        if (n > hi) test_done();
    endtask : await

    task automatic watch(input int cycles);
        all_loss = 2'b11;
        any_loss = 2'b00;
        any_rail = 2'b00;
        repeat (cycles) begin
            @(posedge clk_sys);
            all_loss &= loss;
            any_loss |= loss;
            any_rail |= rpos | rneg;
        end
    endtask : watch

    task automatic test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check({30'h0, loss}, 32'h0000_0000);
        check({31'h0, host_int_n}, 32'h0000_0001);
        apb(1'b0, LLSD_ADR_CTRL, LLSD_CTRL_RST, 1'b0);
        apb(1'b0, LLSD_ADR_IEN, {28'h0, LLSD_IEN_RST}, 1'b0);
        apb(1'b0, 12'h010, 32'h0000_0000, 1'b1);
        // Pin-selected E3 timing must hide a short amplitude drop.
        hwe3[1] <= 1'b1;
        low[1] <= 1'b1;
        watch(20);
        check({31'h0, any_loss[1]}, 32'h0000_0000);
        low[1] <= 1'b0;
        hwe3[1] <= 1'b0;
        // Pin mode: dead line, then sparse pulses that must not clear.
        mute <= 1'b1;
        period[0] <= 3'h0;
        await(0, 1'b1, 100, 250);
        check({31'h0, loss[1]}, 32'h0000_0000);
        period[0] <= 3'h4;
        onef <= 1'b1;
        watch(400);
        check({31'h0, all_loss[0]}, 32'h0000_0001);
        onef <= 1'b0;
        period[0] <= 3'h2;
        await(0, 1'b0, 1, 400);
        mute <= 1'b0;
        // Host mode: amplitude loss, status, interrupt and mute bit.
        css <= 1'b1;
        apb(1'b1, LLSD_ADR_IST, 32'h0000_000F, 1'b0);
        apb(1'b1, LLSD_ADR_IEN, 32'h0000_0006, 1'b0);
        low[1] <= 1'b1;
        await(1, 1'b1, 1, 5);
        apb(1'b0, LLSD_ADR_STAT, 32'h0000_0600, 1'b0);
        check({31'h0, host_int_n}, 32'h0000_0000);
        apb(1'b0, LLSD_ADR_IST, 32'h0000_0004, 1'b0);
        apb(1'b1, LLSD_ADR_IST, 32'h0000_0004, 1'b0);
        @(posedge clk_sys);
        check({31'h0, host_int_n}, 32'h0000_0001);
        apb(1'b1, LLSD_ADR_CTRL, 32'h0000_0200, 1'b0);
        watch(8);
        check({31'h0, any_rail[1]}, 32'h0000_0000);
        // Both disables on channel 1 only.
        apb(1'b1, LLSD_ADR_CTRL, 32'h0000_0E00, 1'b0);
        await(1, 1'b0, 0, 5);
        low[0] <= 1'b1;
        watch(20);
        check({31'h0, any_loss[1]}, 32'h0000_0000);
        check({31'h0, loss[0]}, 32'h0000_0001);
        dfa[0] <= 1'b1;
        watch(5);
        check({31'h0, host_int_n}, 32'h0000_0000);
        apb(1'b1, LLSD_ADR_IST, 32'h0000_000F, 1'b0);
        @(posedge clk_sys);
        check({31'h0, host_int_n}, 32'h0000_0001);
        // E3 declaration and clearance timing on channel 0.
        low <= 2'b00;
        apb(1'b1, LLSD_ADR_CTRL, 32'h0000_0001, 1'b0);
        await(0, 1'b0, 0, 10);
        low[0] <= 1'b1;
        await(0, 1'b1, 100, 250);
        low[0] <= 1'b0;
        await(0, 1'b0, 10, 255);
        test_done();
    end
endmodule : llsd_top_test

bind llsd_top llsd_props llsd_props_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .control_source_select(control_source_select),
    .loss_data_mute(loss_data_mute),
    .single_frequency_operation(single_frequency_operation),
    .line_in(line_in), .receive_clock_out(receive_clock_out),
    .receive_positive_rail(receive_positive_rail),
    .receive_negative_rail(receive_negative_rail),
    .combined_receive_loss(combined_receive_loss), .host_int_n(host_int_n));
`default_nettype wire

// *** include/llsd_pkg.sv ***
`default_nettype none
package llsd_pkg;

    // ****************************************************************
    // Register map, byte addresses on APB.
    // ****************************************************************
    localparam logic [11:0] LLSD_ADR_CTRL = 12'h000;
    localparam logic [11:0] LLSD_ADR_STAT = 12'h004;
    localparam logic [11:0] LLSD_ADR_IEN  = 12'h008;
    localparam logic [11:0] LLSD_ADR_IST  = 12'h00C;

    // Control field positions, channel n starts at bit 8*n.
    localparam int LLSD_CH_STRIDE  = 8;
    localparam int LLSD_F_E3       = 0;
    localparam int LLSD_F_MUTE     = 1;
    localparam int LLSD_F_ADIS     = 2;
    localparam int LLSD_F_DDIS     = 3;
    // Status fields per channel.
    localparam int LLSD_F_DIG      = 0;
    localparam int LLSD_F_ANA      = 1;
    localparam int LLSD_F_COMB     = 2;
    // Interrupt bits: two per channel, 2*n + field.
    localparam int LLSD_I_COMB     = 0;
    localparam int LLSD_I_DRV      = 1;

    localparam logic [31:0] LLSD_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0]  LLSD_IEN_RST  = 4'h0;

    // ****************************************************************
    // Detection counts, in line symbol periods.
    // ****************************************************************
    localparam logic [7:0] LLSD_ZERO_DECL = 8'd175;
    localparam logic [7:0] LLSD_WIN_LEN   = 8'd175;
    // More than 33 percent of the window must carry pulses.
    localparam logic [7:0] LLSD_DENS_MIN  =
        8'((32'd175 * 32'd33) / 32'd100 + 32'd1);
    localparam logic [7:0] LLSD_E3_DECL   = 8'd175;
    localparam logic [7:0] LLSD_E3_CLR    = 8'd175;

    // Line side inputs of one channel, all synchronous to clk_sys.
    typedef struct packed {
        logic sym_valid;   // One-cycle strobe per line symbol.
        logic pos;         // Recovered positive rail.
        logic neg;         // Recovered negative rail.
        logic level_low;   // Amplitude comparator, with hysteresis.
        logic rec_clk;     // Recovered clock level.
        logic ref_clk;     // Rate reference clock level.
        logic syn_clk;     // Internally synthesised rate clock level.
    } llsd_line_t;

    typedef struct packed {
        logic e3;
        logic mute;
        logic adis;
        logic ddis;
        logic one_freq;
    } llsd_cfg_t;

    typedef struct packed {
        logic dig_loss;
        logic ana_loss;
        logic comb_loss;
    } llsd_stat_t;

    typedef enum logic {
        LLSD_DIG_OK   = 1'b0,
        LLSD_DIG_LOSS = 1'b1
    } llsd_dig_t;

endpackage : llsd_pkg
`default_nettype wire

// *** rtl/llsd_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
module llsd_chan
    import llsd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire llsd_cfg_t  cfg,
    input  wire llsd_line_t line,
    output var  llsd_stat_t stat,
    output var  logic       rclk_out,
    output var  logic       rpos_out,
    output var  logic       rneg_out
);

    // ****************************************************************
    // Digital loss: zero run and pulse density window.
    // ****************************************************************
    llsd_dig_t  dig_r;
    llsd_dig_t  dig_nxt;
    logic [7:0] zrun_r;
    logic [7:0] win_r;
    logic [7:0] ones_r;
    logic       e3los_r;
    logic [7:0] e3cnt_r;
    logic       pulse;
    logic       zdecl;
    logic       win_end;
    logic       dense;
    logic       ana_w;
    logic       e3_diff;
    logic       e3_hit;
    logic       comb_w;

    assign pulse   = line.pos | line.neg;
    assign zdecl   = ~pulse && (zrun_r == LLSD_ZERO_DECL - 8'd1);
    assign win_end = (win_r == LLSD_WIN_LEN - 8'd1);
    // The pulse of the closing symbol counts towards the window.
    assign dense   = (ones_r + {7'd0, pulse}) >= LLSD_DENS_MIN;

    // Next digital state, only moved on a symbol strobe.
    always_comb begin
        dig_nxt = dig_r;
        case (dig_r)
            LLSD_DIG_OK: begin
                if (line.sym_valid && zdecl) begin
                    dig_nxt = LLSD_DIG_LOSS;
                end
            end
            LLSD_DIG_LOSS: begin
                if (line.sym_valid && win_end && dense) begin
                    dig_nxt = LLSD_DIG_OK;
                end
            end
            default: dig_nxt = LLSD_DIG_OK;
        endcase
    end

    // Zero run counts every symbol; the window runs only in loss and restarts on a sparse miss.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dig_r  <= LLSD_DIG_OK;
            zrun_r <= 8'd0;
            win_r  <= 8'd0;
            ones_r <= 8'd0;
        end else if (line.sym_valid) begin
            dig_r  <= dig_nxt;
            zrun_r <= (pulse || zdecl) ? 8'd0 : zrun_r + 8'd1;
            win_r  <= (win_end || dig_r == LLSD_DIG_OK) ? 8'd0
                                                       : win_r + 8'd1;
            ones_r <= (win_end || dig_r == LLSD_DIG_OK) ? 8'd0
                                          : ones_r + {7'd0, pulse};
        end
    end

    // ****************************************************************
    // Analog loss: follows comparator, or E3 timed declare and clear.
    // ****************************************************************
    assign e3_diff = line.level_low ^ e3los_r;
    assign e3_hit  = e3_diff && (e3cnt_r == (e3los_r ? LLSD_E3_CLR
                                                    : LLSD_E3_DECL)
                                            - 8'd1);

    // A restored period during the run restarts the count.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            e3los_r <= 1'b0;
            e3cnt_r <= 8'd0;
        end else if (line.sym_valid) begin
            e3los_r <= e3los_r ^ e3_hit;
            e3cnt_r <= (e3_diff && !e3_hit) ? e3cnt_r + 8'd1 : 8'd0;
        end
    end

    assign ana_w  = cfg.e3 ? e3los_r : line.level_low;
    // Only both disables together suppress the channel's loss.
    assign comb_w = ~(cfg.adis & cfg.ddis) &
                    ((dig_r == LLSD_DIG_LOSS) | ana_w);

    // ****************************************************************
    // Registered status and receive outputs.
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stat     <= '0;
            rclk_out <= 1'b0;
            rpos_out <= 1'b0;
            rneg_out <= 1'b0;
        end else begin
            stat.dig_loss  <= (dig_r == LLSD_DIG_LOSS);
            stat.ana_loss  <= ana_w;
            stat.comb_loss <= comb_w;
            rclk_out  <= !comb_w ? line.rec_clk :
                         (cfg.one_freq ? line.syn_clk
                                       : line.ref_clk);
            rpos_out  <= line.pos & ~(comb_w & cfg.mute);
            rneg_out  <= line.neg & ~(comb_w & cfg.mute);
        end
    end

endmodule : llsd_chan
`default_nettype wire

// *** rtl/llsd_top.sv ***
// Functional notes
// - Declare digital loss after 175 zeros.
// - Clear digital loss above 33% density.
// - Analog loss bit follows comparator.
// - Combined loss is digital OR analog.
// - Combined loss drives pin and status.
// - Both disables suppress that channel only.
// - E3 declares after 175 low periods.
// - E3 declare within 10 to 255 UI.
// - E3 clear within 10 to 255 UI.
// - Loss puts reference clock on output.
// - Single-frequency loss uses synthesised clock.
// - Mute forces both rails to zero during loss.
// - Recovered data returns after loss clears.
// - Host select picks registers or pins.
// - Host mode active-low alarm interrupt.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module llsd_top
    import llsd_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output var  logic             pready,
    output var  logic [31:0]      prdata,
    output var  logic             pslverr,
    input  wire logic             control_source_select,
    input  wire logic [1:0]       hw_e3_select,
    input  wire logic             loss_data_mute,
    input  wire logic             single_frequency_operation,
    input  wire llsd_line_t [1:0] line_in,
    input  wire logic [1:0]       driver_fault_alarm,
    output var  logic [1:0]       receive_clock_out,
    output var  logic [1:0]       receive_positive_rail,
    output var  logic [1:0]       receive_negative_rail,
    output var  logic [1:0]       combined_receive_loss,
    output var  logic             host_int_n
);

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // True when the bus address selects the given register word.
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    logic        acc;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_ien;
    logic        hit_ist;
    logic        mapped;
    logic        commit;
    logic        wr_ctrl;
    logic        wr_ien;
    logic        wr_ist;

    logic [31:0] ctrl_r;
    logic [3:0]  ien_r;
    logic [3:0]  ist_r;
    logic [3:0]  ist_nxt;
    logic [3:0]  ev;
    logic [1:0]  comb_d_r;
    logic [1:0]  drv_d_r;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;

    llsd_cfg_t   cfg      [1:0];
    llsd_stat_t  ch_stat  [1:0];
    logic [1:0]  ch_comb;

    // The access phase takes two cycles: pready is a flop raised in
    // the second, so the read word and the error are registered too.
    assign acc      = psel & penable;
    assign commit   = acc & pready;
    assign hit_ctrl = hit(paddr, LLSD_ADR_CTRL);
    assign hit_stat = hit(paddr, LLSD_ADR_STAT);
    assign hit_ien  = hit(paddr, LLSD_ADR_IEN);
    assign hit_ist  = hit(paddr, LLSD_ADR_IST);
    assign mapped   = hit_ctrl | hit_stat | hit_ien | hit_ist;
    assign wr_ctrl  = commit & pwrite & hit_ctrl;
    assign wr_ien   = commit & pwrite & hit_ien;
    assign wr_ist   = commit & pwrite & hit_ist;

    // ****************************************************************
    // APB handshake and read data.
    // ****************************************************************

    // Read word for the addressed register; unmapped reads return 0.
    assign rd_mux = hit_ctrl ? ctrl_r                       :
                    hit_stat ? stat_word                    :
                    hit_ien  ? {28'd0, ien_r}               :
                    hit_ist  ? {28'd0, ist_r}               :
                               32'h0000_0000;

    // Ready follows the access cycle by one; it drops after the commit.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_mux
                                                 : 32'h0000_0000;
            pslverr <= acc & ~pready & ~mapped;
        end
    end

    // ****************************************************************
    // Control and interrupt enable registers.
    // ****************************************************************

    // Writes land only at the edge where pready is seen high.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= LLSD_CTRL_RST;
            ien_r  <= LLSD_IEN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= pwdata;
            end
            if (wr_ien) begin
                ien_r <= pwdata[3:0];
            end
        end
    end

    // ****************************************************************
    // Channels.
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            localparam int B = ch * LLSD_CH_STRIDE;

            // Host mode takes E3, mute and the disables from the control word; single frequency is always the pin; pin mode the pins, with
            // detection always enabled since the disables have no pin.
            assign cfg[ch].e3   = control_source_select
                                ? ctrl_r[B + LLSD_F_E3]
                                : hw_e3_select[ch];
            assign cfg[ch].mute = control_source_select
                                ? ctrl_r[B + LLSD_F_MUTE]
                                : loss_data_mute;
            assign cfg[ch].adis = control_source_select
                                & ctrl_r[B + LLSD_F_ADIS];
            assign cfg[ch].ddis = control_source_select
                                & ctrl_r[B + LLSD_F_DDIS];
            assign cfg[ch].one_freq = single_frequency_operation;

            // Each instance owns all of its detection state.
            llsd_chan u_chan (
                .clk_sys  (clk_sys),
                .arst_n   (arst_n),
                .cfg      (cfg[ch]),
                .line     (line_in[ch]),
                .stat     (ch_stat[ch]),
                .rclk_out (receive_clock_out[ch]),
                .rpos_out (receive_positive_rail[ch]),
                .rneg_out (receive_negative_rail[ch])
            );

            assign ch_comb[ch] = ch_stat[ch].comb_loss;

            // Status word fields for this channel.
            assign stat_word[B + LLSD_F_DIG]  = ch_stat[ch].dig_loss;
            assign stat_word[B + LLSD_F_ANA]  = ch_stat[ch].ana_loss;
            assign stat_word[B + LLSD_F_COMB] = ch_stat[ch].comb_loss;
            assign stat_word[B + LLSD_CH_STRIDE - 1 :
                             B + LLSD_F_COMB + 1] = '0;

            // Rising edges of loss and of the driver alarm are events.
            assign ev[2*ch + LLSD_I_COMB] = ch_stat[ch].comb_loss
                                          & ~comb_d_r[ch];
            assign ev[2*ch + LLSD_I_DRV]  = driver_fault_alarm[ch]
                                          & ~drv_d_r[ch];
        end
    endgenerate

    assign stat_word[31:2*LLSD_CH_STRIDE] = '0;

    // ****************************************************************
    // Loss pins and alarm interrupt.
    // ****************************************************************

    // Write one to clear; an event in the same cycle keeps its bit.
    assign ist_nxt = (ist_r & ~(wr_ist ? pwdata[3:0] : 4'h0)) | ev;

    // The pin copy of combined loss is one flop behind the status bit,
    // which keeps the output free of logic after the flop.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            comb_d_r              <= 2'b00;
            drv_d_r               <= 2'b00;
            ist_r                 <= 4'h0;
            combined_receive_loss <= 2'b00;
            host_int_n            <= 1'b1;
        end else begin
            comb_d_r              <= ch_comb;
            drv_d_r               <= driver_fault_alarm;
            ist_r                 <= ist_nxt;
            combined_receive_loss <= ch_comb;
            // The shared pin is only an interrupt in host mode.
            host_int_n <= ~(control_source_select
                            & |(ist_nxt & ien_r));
        end
    end

endmodule : llsd_top
`default_nettype wire
